// >>> sfqpc_core.sv
// Behaviour
// - table bytes 36h,37h read D5h,5Ch
// - table bytes 38h..3Bh read 00h,F6h,59h,FFh
// - instruction ABh leaves deep sleep
// - three microsecond wait after wake-up
// - status byte one bit 0 shows busy
// - quad enable is bit 1, read by 35h
// - 01h with two bytes writes quad enable
// - mode bits A5h keep continuous read
// - mode bits 00h end continuous read
// - eight clocks of ones end continuous read
// - quad-address read with four data lines
// - no way to disable hold, protect
// - instruction B9h enters deep sleep
//
// Local design decisions: the strobed register port and the register offsets.
`default_nettype none

module sfqpc_core #(
   parameter int WRSR_NS = 1000
) (
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         spi_clk,
   input  wire logic                         spi_cs_n,
   input  wire logic [3:0]                   spi_io_in,
   output var  logic [3:0]                   spi_io_out,
   output var  logic [3:0]                   spi_io_oe,
   input  wire logic [sfqpc_pkg::REG_AW-1:0] reg_addr,
   input  wire logic [sfqpc_pkg::REG_DW-1:0] reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output var  logic [sfqpc_pkg::REG_DW-1:0] reg_rdata,
   output var  logic                         irq
);
   import sfqpc_pkg::*;

   localparam int WRSR_CYC = (WRSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [BUSY_W-1:0] TRES_LOAD = BUSY_W'(TRES_CYC);
   localparam logic [BUSY_W-1:0] WRSR_LOAD = BUSY_W'(WRSR_CYC);

   if (WRSR_CYC < 1 || WRSR_CYC >= 2 ** BUSY_W || TRES_CYC >= 2 ** BUSY_W)
      $error("busy times do not fit the busy counter");

   // pin sampling
   logic [5:0]      s1_reg, s2_reg, s3_reg, flt_reg;
   logic [5:0]      flt_next;
   logic            sck_rise, sck_fall, cs_fall, cs_rise, sel;
   logic [3:0]      io_now;

   // frame state
   sfqpc_state_type st_reg, st_next, cmd_st;
   logic [4:0]      cnt_reg, cnt_next;
   logic [7:0]      cmd_reg, cmd_next, cmd_in;
   logic [23:0]     sh_reg, sh_next;
   logic [7:0]      mode_reg, mode_next;
   logic            ones_reg, ones_next;
   logic [7:0]      out_reg, out_next, byte_src;
   logic [2:0]      ocnt_reg, ocnt_next;
   logic            first_reg, first_next;
   logic [7:0]      ptr_reg, ptr_next;
   logic            quad_out, out_phase;
   logic [3:0]      io_o_next, oe_next;

   // device state
   logic              dpd_reg, dpd_next;
   logic              qe_reg, qe_next, qe_in;
   logic              cont_reg, cont_next;
   logic [BUSY_W-1:0] busy_reg, busy_next;
   logic              operation_in_progress_flag, busy;
   logic [7:0]        sr1, sr2;
   logic [NEV-1:0]    ev;

   // register file
   logic              force_reg;
   logic [NEV-1:0]    mask_reg, stat_reg, stat_next;
   logic [3:0]        state_bits;
   logic [REG_DW-1:0] rd_mux;
   logic              rd_stat, wr_mask, wr_ctrl;

   sfqpc_rom_if rom_bus ();

   sfqpc_sfdp_rom u_rom (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .bus     (rom_bus.rom)
   );

   assign rom_bus.addr = ptr_reg;

   // a pin level moves only when the second and third stages agree
   assign flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
   assign sck_rise = flt_next[5] & ~flt_reg[5];
   assign sck_fall = ~flt_next[5] & flt_reg[5];
   assign cs_fall  = ~flt_next[4] & flt_reg[4];
   assign cs_rise  = flt_next[4] & ~flt_reg[4];
   assign sel      = ~flt_next[4];
   assign io_now   = flt_next[3:0];

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         s1_reg  <= PIN_IDLE;
         s2_reg  <= PIN_IDLE;
         s3_reg  <= PIN_IDLE;
         flt_reg <= PIN_IDLE;
      end
      else
      begin
         s1_reg  <= {spi_clk, spi_cs_n, spi_io_in};
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         flt_reg <= flt_next;
      end
   end

   assign operation_in_progress_flag    = (busy_reg != '0) | force_reg;
   assign busy   = operation_in_progress_flag;
   assign sr1    = 8'(operation_in_progress_flag) << SR1_BUSY_BIT;
   assign sr2    = 8'(qe_reg) << SR2_QE_BIT;
   assign cmd_in = {sh_reg[6:0], io_now[DI_PIN]};
   assign qe_in  = sh_reg[SR2_QE_BIT];

   // asleep only the wake code is heard; busy only the busy poll
   assign cmd_st = dpd_reg ? ((cmd_in == OP_WAKE) ? S_TAIL : S_IGNORE) :
                   (cmd_in == OP_RD_SR1) ? S_SOUT :
                   busy ? S_IGNORE :
                   (cmd_in == OP_RD_SR2) ? S_SOUT :
                   (cmd_in == OP_WR_SR)  ? S_WRSR :
                   (cmd_in == OP_RD_TBL) ? S_SADDR :
                   (cmd_in == OP_QREAD && qe_reg) ? S_QADDR :
                   (cmd_in == OP_SLEEP)  ? S_TAIL :
                   S_IGNORE;

   assign byte_src = (cmd_next == OP_QREAD)  ? ERASED :
                     (cmd_next == OP_RD_SR1) ? sr1 :
                     (cmd_next == OP_RD_SR2) ? sr2 :
                     rom_bus.data;

   assign out_phase = (st_reg == S_SOUT) || (st_reg == S_QOUT);
   assign quad_out  = (st_reg == S_QOUT);

   always_comb
   begin
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      cmd_next   = cmd_reg;
      sh_next    = sh_reg;
      mode_next  = mode_reg;
      ones_next  = ones_reg;
      out_next   = out_reg;
      ocnt_next  = ocnt_reg;
      first_next = first_reg;
      ptr_next   = ptr_reg;
      if (!sel)
         st_next = S_IDLE;
      else if (cs_fall)
      begin
         // a continuous-mode frame carries no instruction byte
         st_next   = cont_reg ? S_QADDR : S_CMD;
         cmd_next  = cont_reg ? OP_QREAD : cmd_reg;
         cnt_next  = '0;
         ones_next = 1'b1;
      end
      else if (sck_rise)
      begin
         cnt_next = cnt_reg + 5'h01;
         case (st_reg)
            S_CMD:
            begin
               sh_next = {sh_reg[22:0], io_now[DI_PIN]};
               if (cnt_reg == LAST_BYTE)
               begin
                  st_next  = cmd_st;
                  cmd_next = cmd_in;
                  cnt_next = '0;
               end
            end
            S_SADDR:
            begin
               sh_next = {sh_reg[22:0], io_now[DI_PIN]};
               if (cnt_reg == LAST_SADDR)
               begin
                  st_next  = S_SDUMMY;
                  ptr_next = cmd_in;
                  cnt_next = '0;
               end
            end
            S_SDUMMY:
               if (cnt_reg == LAST_BYTE)
                  st_next = S_SOUT;
            S_WRSR:
            begin
               sh_next = {sh_reg[22:0], io_now[DI_PIN]};
               if (cnt_reg == LAST_WRSR)
                  st_next = S_TAIL;
            end
            // any clock past a complete instruction voids it
            S_TAIL:
               st_next = S_IGNORE;
            S_QADDR:
            begin
               sh_next   = {sh_reg[19:0], io_now};
               ones_next = ones_reg & (io_now == ONES_NIB);
               if (cnt_reg == LAST_QADDR)
               begin
                  st_next  = S_QMODE;
                  cnt_next = '0;
               end
            end
            S_QMODE:
            begin
               mode_next = {mode_reg[3:0], io_now};
               ones_next = ones_reg & (io_now == ONES_NIB);
               if (cnt_reg == LAST_QMODE)
               begin
                  st_next  = S_QDUMMY;
                  cnt_next = '0;
               end
            end
            S_QDUMMY:
               if (cnt_reg == LAST_QDUMMY)
                  st_next = S_QOUT;
            default:
               ;
         endcase
         if ((st_next == S_SOUT || st_next == S_QOUT) && !out_phase)
         begin
            out_next   = byte_src;
            ptr_next   = ptr_reg + 8'h01;
            ocnt_next  = '0;
            first_next = 1'b1;
         end
      end
      else if (sck_fall && out_phase)
      begin
         // the first bit already stands from the load on the rising edge
         if (first_reg)
            first_next = 1'b0;
         else if (ocnt_reg == (quad_out ? LAST_QNIB : LAST_SBIT))
         begin
            out_next  = byte_src;
            ptr_next  = ptr_reg + 8'h01;
            ocnt_next = '0;
         end
         else
         begin
            out_next  = quad_out ? {out_reg[3:0], 4'h0} : {out_reg[6:0], 1'b0};
            ocnt_next = ocnt_reg + 3'h1;
         end
      end
   end

   // effects of a completed frame land on the rising chip select
   always_comb
   begin
      dpd_next  = dpd_reg;
      qe_next   = qe_reg;
      cont_next = cont_reg;
      busy_next = (busy_reg != '0) ? busy_reg - 1'b1 : busy_reg;
      ev        = '0;
      if (cs_rise && st_reg == S_TAIL)
      begin
         case (cmd_reg)
            OP_WAKE:
            begin
               dpd_next        = 1'b0;
               busy_next       = TRES_LOAD;
               ev[EV_WAKE]     = 1'b1;
            end
            OP_SLEEP:
            begin
               dpd_next        = 1'b1;
               ev[EV_SLEEP]    = 1'b1;
            end
            OP_WR_SR:
            begin
               qe_next         = qe_in;
               busy_next       = WRSR_LOAD;
               ev[EV_QE_WRITE] = 1'b1;
            end
            default:
               ;
         endcase
      end
      if (cs_rise && (st_reg == S_QDUMMY || st_reg == S_QOUT))
      begin
         // only A5h keeps the mode; 00h, the ones reset and all else leave it
         cont_next         = (mode_reg == MODE_KEEP) && !ones_reg;
         ev[EV_CONT_EXIT]  = cont_reg && !cont_next;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_reg    <= S_IDLE;
         cnt_reg   <= '0;
         cmd_reg   <= '0;
         sh_reg    <= '0;
         mode_reg  <= '0;
         ones_reg  <= 1'b0;
         out_reg   <= '0;
         ocnt_reg  <= '0;
         first_reg <= 1'b0;
         ptr_reg   <= '0;
      end
      else
      begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         cmd_reg   <= cmd_next;
         sh_reg    <= sh_next;
         mode_reg  <= mode_next;
         ones_reg  <= ones_next;
         out_reg   <= out_next;
         ocnt_reg  <= ocnt_next;
         first_reg <= first_next;
         ptr_reg   <= ptr_next;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         dpd_reg  <= 1'b0;
         qe_reg   <= 1'b0;
         cont_reg <= 1'b0;
         busy_reg <= '0;
      end
      else
      begin
         dpd_reg  <= dpd_next;
         qe_reg   <= qe_next;
         cont_reg <= cont_next;
         busy_reg <= busy_next;
      end
   end

   // io2 and io3 turn to data only in the quad phases, nothing disables them
   assign io_o_next = quad_out ? out_reg[7:4] : 4'(out_reg[7]) << DO_PIN;
   assign oe_next   = (!sel || !out_phase) ? 4'h0 :
                      quad_out ? 4'hf : 4'(1'b1) << DO_PIN;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         spi_io_out <= '0;
         spi_io_oe  <= '0;
      end
      else
      begin
         spi_io_out <= io_o_next;
         spi_io_oe  <= oe_next;
      end
   end

   // register port
   assign rd_stat    = reg_rd && (reg_addr == OFF_IRQ_STAT);
   assign wr_mask    = reg_wr && (reg_addr == OFF_IRQ_MASK);
   assign wr_ctrl    = reg_wr && (reg_addr == OFF_CTRL);
   // set wins over the clear of a status read in the same cycle
   assign stat_next  = (rd_stat ? '0 : stat_reg) | ev;
   assign state_bits = {cont_reg, dpd_reg, qe_reg, operation_in_progress_flag};
   assign rd_mux     = (reg_addr == OFF_IRQ_STAT) ? REG_DW'(stat_reg) :
                       (reg_addr == OFF_IRQ_MASK) ? REG_DW'(mask_reg) :
                       (reg_addr == OFF_STATE)    ? REG_DW'(state_bits) :
                       (reg_addr == OFF_CTRL)     ? REG_DW'(force_reg) :
                       '0;
   assign irq        = |(stat_reg & mask_reg);

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         stat_reg  <= '0;
         mask_reg  <= '0;
         force_reg <= 1'b0;
         reg_rdata <= '0;
      end
      else
      begin
         stat_reg  <= stat_next;
         reg_rdata <= reg_rd ? rd_mux : '0;
         if (wr_mask)
            mask_reg <= reg_wdata[NEV-1:0];
         if (wr_ctrl)
            force_reg <= reg_wdata[0];
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_wake_release:
   assert property (cs_rise && st_reg == S_TAIL && cmd_reg == OP_WAKE |=>
                    !dpd_reg && busy_reg == TRES_LOAD)
      else $error("wake code did not leave deep sleep");

   a_wait_refuses:
   assert property (st_reg == S_CMD && sck_rise && cnt_reg == LAST_BYTE && !dpd_reg &&
                    busy_reg != '0 && cmd_in != OP_RD_SR1 |=> st_reg == S_IGNORE)
      else $error("instruction taken during the wait");

   a_busy_bit:
   assert property (st_reg == S_CMD && st_next == S_SOUT && cmd_next == OP_RD_SR1 |=>
                    out_reg[SR1_BUSY_BIT] == $past(operation_in_progress_flag) && spi_io_oe == 4'h0)
      else $error("busy bit not loaded");

   a_qe_readback:
   assert property (st_reg == S_CMD && st_next == S_SOUT && cmd_next == OP_RD_SR2 |=>
                    out_reg[SR2_QE_BIT] == $past(qe_reg))
      else $error("quad enable not in status byte two");

   a_qe_write:
   assert property (cs_rise && st_reg == S_TAIL && cmd_reg == OP_WR_SR |=>
                    qe_reg == $past(qe_in) && busy_reg == WRSR_LOAD)
      else $error("status write missed quad enable");

   a_quad_gate:
   assert property (st_reg == S_CMD && sck_rise && cnt_reg == LAST_BYTE && cmd_in == OP_QREAD &&
                    !qe_reg |=> st_reg == S_IGNORE)
      else $error("quad read without quad enable");

   a_cont_keep:
   assert property (cs_rise && st_reg == S_QOUT && mode_reg == MODE_KEEP && !ones_reg |=>
                    cont_reg)
      else $error("continuous mode lost");

   a_cont_exit:
   assert property (cs_rise && st_reg == S_QOUT && mode_reg == MODE_EXIT |=> !cont_reg)
      else $error("continuous mode kept after exit code");

   a_ones_exit:
   assert property (cs_rise && st_reg == S_QDUMMY && ones_reg |=> !cont_reg ##1 !cont_reg)
      else $error("ones reset ignored");

   a_cont_frame:
   assert property (cs_fall && cont_reg |=> st_reg == S_QADDR ##1 st_reg != S_CMD)
      else $error("continuous frame expected an instruction");

   a_sleep_entry:
   assert property (cs_rise && st_reg == S_TAIL && cmd_reg == OP_SLEEP |=> dpd_reg &&
                    stat_reg[EV_SLEEP])
      else $error("sleep code ignored");

endmodule // sfqpc_core

`default_nettype wire

// >>> sfqpc_host.sv
`default_nettype none

module sfqpc_host (
   input  wire logic       ref_clk,
   output var  logic       spi_clk,
   output var  logic       spi_cs_n,
   output wire logic [3:0] spi_io_in,
   input  wire logic [3:0] spi_io_out,
   input  wire logic [3:0] spi_io_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0]  drv = 4'hf;
   logic [31:0] rx  = 32'h0;

   initial
   begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
   end

   assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & drv);

   task automatic half();
      repeat (20) @(posedge ref_clk);
   endtask

   // released lines toggle so a stale level never matches by luck; hold and protect stay high outside quad frames
   task automatic shift(input logic [31:0] v, input int n, input bit quad, input bit rel);
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge ref_clk);
         spi_cs_n <= 1'b0;
         if (rel)
            drv <= quad ? ~drv : {2'h3, ~drv[1:0]};
         else
            drv <= quad ? v[4*i +: 4] : {3'h7, v[i]};
         half();
         spi_clk <= 1'b1;
         rx <= quad ? {rx[27:0], spi_io_in} : {rx[30:0], spi_io_in[1]};
         half();
         spi_clk <= 1'b0;
      end
   endtask

   task automatic stop();
      half();
      spi_cs_n <= 1'b1;
      repeat (40) @(posedge ref_clk);
   endtask
endmodule // sfqpc_host

`default_nettype wire

// >>> sfqpc_pkg.sv
`default_nettype none

package sfqpc_pkg;

   localparam int CLK_PERIOD_NS = 4;

   // wait after leaving deep sleep is (count + 1) * unit
   localparam int DPD_UNIT_NS   = 1000;
   localparam int DPD_COUNT     = 2;
   localparam int TRES_NS       = (DPD_COUNT + 1) * DPD_UNIT_NS;
   localparam int TRES_CYC      = (TRES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_W        = 16;

   localparam logic [7:0] OP_RD_SR1  = 8'h05;
   localparam logic [7:0] OP_RD_SR2  = 8'h35;
   localparam logic [7:0] OP_WR_SR   = 8'h01;
   localparam logic [7:0] OP_RD_TBL  = 8'h5a;
   localparam logic [7:0] OP_QREAD   = 8'heb;
   localparam logic [7:0] OP_WAKE    = 8'hab;
   localparam logic [7:0] OP_SLEEP   = 8'hb9;

   localparam logic [7:0] MODE_KEEP  = 8'ha5;
   localparam logic [7:0] MODE_EXIT  = 8'h00;
   localparam logic [3:0] ONES_NIB   = 4'hf;
   localparam logic [7:0] ERASED     = 8'hff;

   localparam int SR1_BUSY_BIT = 0;
   localparam int SR2_QE_BIT   = 1;
   localparam int DO_PIN       = 1;
   localparam int DI_PIN       = 0;

   // phase lengths in link clocks, minus one
   localparam logic [4:0] LAST_BYTE   = 5'h07;
   localparam logic [4:0] LAST_SADDR  = 5'h17;
   localparam logic [4:0] LAST_WRSR   = 5'h0f;
   localparam logic [4:0] LAST_QADDR  = 5'h05;
   localparam logic [4:0] LAST_QMODE  = 5'h01;
   localparam logic [4:0] LAST_QDUMMY = 5'h03;
   localparam logic [2:0] LAST_SBIT   = 3'h7;
   localparam logic [2:0] LAST_QNIB   = 3'h1;

   localparam logic [7:0] TBL_A36 = 8'h36;
   localparam logic [7:0] TBL_A37 = 8'h37;
   localparam logic [7:0] TBL_A38 = 8'h38;
   localparam logic [7:0] TBL_A39 = 8'h39;
   localparam logic [7:0] TBL_A3A = 8'h3a;
   localparam logic [7:0] TBL_A3B = 8'h3b;
   localparam logic [7:0] TBL_V36 = 8'hd5;
   localparam logic [7:0] TBL_V37 = 8'h5c;
   localparam logic [7:0] TBL_V38 = 8'h00;
   localparam logic [7:0] TBL_V39 = 8'hf6;
   localparam logic [7:0] TBL_V3A = 8'h59;
   localparam logic [7:0] TBL_V3B = 8'hff;

   localparam int REG_AW = 8;
   localparam int REG_DW = 32;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h00;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFF_STATE    = 8'h08;
   localparam logic [7:0] OFF_CTRL     = 8'h0c;

   localparam int NEV          = 4;
   localparam int EV_SLEEP     = 0;
   localparam int EV_WAKE      = 1;
   localparam int EV_QE_WRITE  = 2;
   localparam int EV_CONT_EXIT = 3;

   // pins as sampled: {sck, cs_n, io[3:0]}, chip select idles high
   localparam logic [5:0] PIN_IDLE = 6'h10;

   typedef enum logic [3:0] {
      S_IDLE, S_CMD, S_SADDR, S_SDUMMY, S_SOUT, S_WRSR, S_TAIL,
      S_QADDR, S_QMODE, S_QDUMMY, S_QOUT, S_IGNORE
   } sfqpc_state_type;

endpackage

`default_nettype wire

// >>> sfqpc_rom_if.sv
`default_nettype none

interface sfqpc_rom_if;
   logic [7:0] addr;
   logic [7:0] data;
   modport user (output addr, input data);
   modport rom  (input addr, output data);
endinterface

`default_nettype wire

// >>> sfqpc_sfdp_rom.sv
`default_nettype none

module sfqpc_sfdp_rom (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   sfqpc_rom_if.rom  bus
);
   import sfqpc_pkg::*;

   logic [7:0] byte_sel;
   logic [7:0] data_reg;

   // bytes outside the held words read as erased
   assign byte_sel = (bus.addr == TBL_A36) ? TBL_V36 :
                     (bus.addr == TBL_A37) ? TBL_V37 :
                     (bus.addr == TBL_A38) ? TBL_V38 :
                     (bus.addr == TBL_A39) ? TBL_V39 :
                     (bus.addr == TBL_A3A) ? TBL_V3A :
                     (bus.addr == TBL_A3B) ? TBL_V3B :
                     ERASED;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         data_reg <= ERASED;
      else
         data_reg <= byte_sel;
   end

   assign bus.data = data_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_tbl_word14:
   assert property ((bus.addr == TBL_A36 || bus.addr == TBL_A37) |=>
                    bus.data == (($past(bus.addr) == TBL_A36) ? TBL_V36 : TBL_V37))
      else $error("parameter word 14 byte wrong");

   a_tbl_word15:
   assert property ((bus.addr == TBL_A38) ##1 (bus.addr == TBL_A39) |=>
                    bus.data == TBL_V39 && $past(bus.data) == TBL_V38)
      else $error("parameter word 15 byte wrong");

   a_tbl_word15_hi:
   assert property ((bus.addr == TBL_A3A || bus.addr == TBL_A3B) |=>
                    bus.data == (($past(bus.addr) == TBL_A3A) ? TBL_V3A : TBL_V3B))
      else $error("parameter word 15 upper byte wrong");

endmodule // sfqpc_sfdp_rom

`default_nettype wire

// >>> testbench.sv
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sfqpc_pkg::*;

   logic        ref_clk;
   logic        sys_rst;
   logic        reg_wr;
   logic        reg_rd;
   logic        rd_d = 1'b0;
   wire  logic  irq;
   wire  logic  spi_clk;
   wire  logic  spi_cs_n;
   wire  logic [3:0] spi_io_in;
   wire  logic [3:0] spi_io_out;
   wire  logic [3:0] spi_io_oe;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   wire  logic [31:0] reg_rdata;
   logic [31:0] lfsr = 32'h3d06db81;
   logic [7:0]  tbl [6] = '{8'hd5, 8'h5c, 8'h00, 8'hf6, 8'h59, 8'hff};
   logic [31:0] exp_q [$];
   string       what_q [$];
   event        spi_ev;
   int          err_count = 0;
   int          compares = 0;
   int          cyc = 0;

   sfqpc_core #(.WRSR_NS(40)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n), .spi_io_in(spi_io_in), .spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));
   sfqpc_host i_host (.ref_clk(ref_clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .spi_io_in(spi_io_in), .spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe));

   function automatic logic [31:0] next_rand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic give_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic note(string what, logic [31:0] exp);
      what_q.push_back(what);
      exp_q.push_back(exp);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, string what, logic [31:0] exp);
      note(what, exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic sread(logic [31:0] v, int n, int rn, string what, logic [7:0] exp);
      note(what, {24'h0, exp});
      i_host.shift(v, n, 1'b0, 1'b0);
      i_host.shift(32'h0, rn, 1'b0, 1'b1);
      i_host.stop();
      -> spi_ev;
   endtask

   task automatic swrite(logic [31:0] v, int n);
      i_host.shift(v, n, 1'b0, 1'b0);
      i_host.stop();
   endtask

   // continuous frames carry no instruction byte
   task automatic qread(bit first, logic [7:0] mode);
      note("quad data", 32'hff);
      if (first)
         i_host.shift({24'h0, OP_QREAD}, 8, 1'b0, 1'b0);
      lfsr = next_rand(lfsr);
      i_host.shift(lfsr, 6, 1'b1, 1'b0);
      i_host.shift({24'h0, mode}, 2, 1'b1, 1'b0);
      i_host.shift(32'h0, 6, 1'b1, 1'b1);
      i_host.stop();
      -> spi_ev;
   endtask

   always @(spi_ev)
      check(what_q.pop_front(), {24'h0, i_host.rx[7:0]}, exp_q.pop_front());

   always @(posedge ref_clk)
   begin
      rd_d <= reg_rd;
      if (rd_d === 1'b1)
         check(what_q.pop_front(), reg_rdata, exp_q.pop_front());
      cyc++;
      if (cyc == 60000)
      begin
         err_count++;
         give_verdict();
      end
   end

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   initial
   begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      lfsr = next_rand(lfsr);
      wr(OFF_IRQ_MASK, lfsr);
      rd(OFF_IRQ_MASK, "mask", {28'h0, lfsr[3:0]});
      rd(8'h10, "unmapped", 32'h0);
      wr(OFF_IRQ_MASK, 32'hf);
      for (int i = 0; i < 6; i++)
         sread({OP_RD_TBL, 16'h0, TBL_A36 + 8'(i)}, 32, 16, "table", tbl[i]);
      sread({24'h0, OP_RD_SR2}, 8, 8, "sr2", 8'h00);
      swrite({8'h0, OP_WR_SR, 16'h0002}, 24);
      repeat (20) @(posedge ref_clk);
      sread({24'h0, OP_RD_SR2}, 8, 8, "sr2", 8'h02);
      check("irq", {31'h0, irq}, 32'h1);
      rd(OFF_IRQ_STAT, "status", 32'h4);
      check("irq", {31'h0, irq}, 32'h0);
      wr(OFF_CTRL, 32'h1);
      sread({24'h0, OP_RD_SR1}, 8, 8, "sr1", 8'h01);
      wr(OFF_CTRL, 32'h0);
      sread({24'h0, OP_RD_SR1}, 8, 8, "sr1", 8'h00);
      swrite({24'h0, OP_SLEEP}, 8);
      rd(OFF_STATE, "state", 32'h6);
      swrite({24'h0, OP_WAKE}, 8);
      // a sleep code inside the wake-up wait must be refused
      swrite({24'h0, OP_SLEEP}, 8);
      rd(OFF_STATE, "state", 32'h3);
      repeat (800) @(posedge ref_clk);
      rd(OFF_STATE, "state", 32'h2);
      rd(OFF_IRQ_STAT, "status", 32'h3);
      // quad enable was set above before any quad read
      qread(1'b1, MODE_KEEP);
      rd(OFF_STATE, "state", 32'ha);
      qread(1'b0, MODE_KEEP);
      rd(OFF_STATE, "state", 32'ha);
      qread(1'b0, MODE_EXIT);
      rd(OFF_STATE, "state", 32'h2);
      qread(1'b1, MODE_KEEP);
      i_host.shift(32'hffffffff, 8, 1'b1, 1'b0);
      i_host.stop();
      rd(OFF_STATE, "state", 32'h2);
      rd(OFF_IRQ_STAT, "status", 32'h8);
      repeat (4) @(posedge ref_clk);
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
